/* hdl/cods_pkg.sv */
// cods_pkg: constants and types for the opcode decode and status byte block
// assumes a single 125 MHz clock domain and an 8-bit processor data path
package cods_pkg;
	// lower status byte field positions
	localparam int LSB_CC_HIGH = 7;
	localparam int LSB_CC_LOW = 6;
	localparam int LSB_HALF_CARRY = 5;
	localparam int LSB_BANK = 4;
	localparam int LSB_CARRY_IN_EN = 3;
	localparam int LSB_OVERFLOW = 2;
	localparam int LSB_UNSIGNED_TEST = 1;
	localparam int LSB_CARRY = 0;
	localparam logic [7:0] LSB_RESET = 8'h00;
	localparam logic [7:0] USB_RESET = 8'h00;
	localparam logic [14:0] PC_RESET = 15'h0000;
	// condition code encodings
	localparam logic [1:0] CC_ZERO = 2'h0;
	localparam logic [1:0] CC_POS = 2'h1;
	localparam logic [1:0] CC_NEG = 2'h2;
	// opcode groups (upper six bits of the first byte)
	localparam logic [5:0] OP_LOAD_Z = 6'h00;
	localparam logic [5:0] OP_LOAD_A = 6'h03;
	localparam logic [5:0] OP_STORE_Z = 6'h30;
	localparam logic [5:0] OP_STORE_R = 6'h32;
	localparam logic [5:0] OP_STORE_A = 6'h33;
	localparam logic [5:0] OP_ADD_Z = 6'h20;
	localparam logic [5:0] OP_SUB_Z = 6'h28;
	localparam logic [5:0] OP_DECIMAL_ADJUST = 6'h25;
	localparam logic [5:0] OP_AND_Z = 6'h10;
	localparam logic [5:0] OP_OR_Z = 6'h18;
	localparam logic [5:0] OP_XOR_Z = 6'h08;
	localparam logic [5:0] OP_CMP_Z = 6'h38;
	localparam logic [5:0] OP_ROTATE_RIGHT = 6'h14;
	localparam logic [5:0] OP_ROTATE_LEFT = 6'h34;
	localparam logic [5:0] OP_BRANCH_TRUE_R = 6'h06;
	localparam logic [5:0] OP_BRANCH_FALSE_R = 6'h26;
	localparam logic [5:0] OP_BRANCH_NZ_R = 6'h16;
	localparam logic [5:0] OP_BRANCH_INCR_R = 6'h36;
	// addressing form in the two low bits of a group code
	localparam logic [1:0] MODE_REG = 2'h0;
	localparam logic [1:0] MODE_IMM = 2'h1;
	localparam logic [1:0] MODE_REL = 2'h2;
	localparam logic [1:0] MODE_ABS = 2'h3;
	// cycle counts per addressing form, and for branch, decimal adjust and rotate
	localparam logic [2:0] CYC_REG = 3'h2;
	localparam logic [2:0] CYC_IMM = 3'h2;
	localparam logic [2:0] CYC_REL = 3'h3;
	localparam logic [2:0] CYC_ABS = 3'h4;
	localparam logic [2:0] CYC_BRANCH = 3'h3;
	localparam logic [2:0] CYC_DECIMAL = 3'h3;
	localparam logic [2:0] CYC_ROTATE = 3'h2;
	// decode sequencer states, gray along fetch path
	typedef enum logic [2:0] {
		CODS_FETCH1 = 3'h0,
		CODS_WAIT1 = 3'h1,
		CODS_FETCH2 = 3'h3,
		CODS_FETCH3 = 3'h2,
		CODS_EXEC = 3'h6,
		CODS_MEM = 3'h7,
		CODS_PAD = 3'h5
	} cods_state_t;
	// memory bus request carrier
	typedef struct packed {
		logic req;
		logic write;
		logic [14:0] addr;
		logic [7:0] wdata;
	} cods_mem_req_t;
	// memory bus answer carrier
	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
	} cods_mem_rsp_t;
endpackage

/* hdl/cods_core.sv */
// cods_core: instruction fetch, decode and status byte update of an 8-bit processor
// assumes program memory answers each request with a one-cycle ack on i_clk
`timescale 1ns/1ps
`default_nettype none
module cods_core
	import cods_pkg::*;
(
	input wire logic i_clk, // 125 MHz clock
	input wire logic i_rst_b, // synchronous reset, active low
	input wire cods_mem_rsp_t i_mem, // memory answer
	input wire logic i_status_we, // lower status byte write strobe
	input wire logic [7:0] i_status_wdata, // lower status byte write data
	input wire logic i_upper_we, // upper status byte write strobe
	input wire logic [7:0] i_upper_wdata, // upper status byte write data
	output cods_mem_req_t o_mem, // memory request
	output logic [7:0] o_lower_status_byte, // lower status byte
	output logic [7:0] o_upper_status_byte, // upper status byte
	output logic [14:0] o_pc, // program counter
	output logic o_illegal, // pulse: invalid r0 form
	output logic o_retire // pulse: instruction done
);
	cods_state_t state, next_state;
	logic [7:0] lsb, next_lsb;
	logic [7:0] usb, next_usb;
	logic [14:0] pc, next_pc;
	logic [7:0] ir, next_ir;
	logic [7:0] b2, next_b2;
	logic [7:0] b3, next_b3;
	logic [7:0] regs [0:6];
	logic [7:0] next_regs [0:6];
	logic [2:0] cyc, next_cyc;
	cods_mem_req_t mem, next_mem;
	logic illegal, next_illegal;
	logic retire, next_retire;
	logic opnd_ready, next_opnd_ready; // memory operand access done
	logic [5:0] op;
	logic [1:0] rf;
	logic [2:0] ri, r0i;
	logic [7:0] rv, r0v;
	logic [1:0] nbytes;
	logic [2:0] ncyc;
	logic [14:0] eaddr;

	// register field to storage index, r0 shared, banks 1..3 / 4..6
	function automatic logic [2:0] cods_idx(input logic [1:0] f, input logic bank);
		if (f == 2'h0) begin
			return 3'h0;
		end
		return bank ? ({1'b0, f} + 3'h3) : {1'b0, f};
	endfunction

	// condition code from a result
	function automatic logic [1:0] cods_cc(input logic [7:0] v);
		if (v == 8'h00) begin
			return CC_ZERO;
		end
		return v[7] ? CC_NEG : CC_POS;
	endfunction

	assign op = ir[7:2];
	assign rf = ir[1:0];
	assign ri = cods_idx(rf, lsb[LSB_BANK]);
	assign r0i = 3'h0;
	assign rv = regs[ri];
	assign r0v = regs[r0i];
	assign eaddr = op[0] ? {b2[6:0], b3} : 15'(pc + {{8{b2[6]}}, b2[6:0]});

	// instruction length and cycle count from the first byte
	always_comb begin
		nbytes = 2'h1;
		ncyc = CYC_REG;
		if (op == OP_DECIMAL_ADJUST) begin
			ncyc = CYC_DECIMAL;
		end else if (op == OP_ROTATE_RIGHT || op == OP_ROTATE_LEFT) begin
			ncyc = CYC_ROTATE;
		end else if (op[1:0] == MODE_REL && op[2]) begin
			nbytes = 2'h2;
			ncyc = CYC_BRANCH;
		end else if (op[1:0] == MODE_ABS && op[2]) begin
			nbytes = 2'h3;
			ncyc = CYC_BRANCH;
		end else begin
			case (op[1:0])
				MODE_IMM: begin
					nbytes = 2'h2;
					ncyc = CYC_IMM;
				end
				MODE_REL: begin
					nbytes = 2'h2;
					ncyc = CYC_REL;
				end
				MODE_ABS: begin
					nbytes = 2'h3;
					ncyc = CYC_ABS;
				end
				default: begin
					nbytes = 2'h1;
					ncyc = CYC_REG;
				end
			endcase
		end
	end

	// fetch, execute and status update
	always_comb begin
		logic [8:0] sum;
		logic [4:0] hsum;
		logic [7:0] opnd, res, dst;
		logic taken, tgt_is_r0, cin;
		sum = 9'h000;
		hsum = 5'h00;
		opnd = 8'h00;
		res = 8'h00;
		dst = 8'h00;
		taken = 1'b0;
		tgt_is_r0 = 1'b0;
		cin = 1'b0;
		next_state = state;
		next_lsb = lsb;
		next_usb = usb;
		next_pc = pc;
		next_ir = ir;
		next_b2 = b2;
		next_b3 = b3;
		next_regs = regs;
		next_cyc = cyc;
		next_mem = mem;
		next_illegal = 1'b0;
		next_retire = 1'b0;
		next_opnd_ready = opnd_ready;
		case (state)
			CODS_FETCH1: begin
				next_mem.req = 1'b1;
				next_mem.write = 1'b0;
				next_mem.addr = pc;
				next_state = CODS_WAIT1;
			end
			CODS_WAIT1: begin
				if (i_mem.ack) begin
					next_mem.req = 1'b0;
					next_ir = i_mem.rdata;
					next_pc = 15'(pc + 15'h0001);
					next_cyc = 3'h1;
					next_state = CODS_FETCH2;
				end
			end
			CODS_FETCH2: begin
				// extra operand bytes as the form asks
				if (nbytes == 2'h1) begin
					next_state = CODS_EXEC;
				end else if (!mem.req) begin
					next_mem.req = 1'b1;
					next_mem.addr = pc;
				end else if (i_mem.ack) begin
					next_mem.req = 1'b0;
					next_b2 = i_mem.rdata;
					next_pc = 15'(pc + 15'h0001);
					next_state = (nbytes == 2'h3) ? CODS_FETCH3 : CODS_EXEC;
				end
			end
			CODS_FETCH3: begin
				if (!mem.req) begin
					next_mem.req = 1'b1;
					next_mem.addr = pc;
				end else if (i_mem.ack) begin
					next_mem.req = 1'b0;
					next_b3 = i_mem.rdata;
					next_pc = 15'(pc + 15'h0001);
					next_state = CODS_EXEC;
				end
			end
			CODS_EXEC: begin
				// memory operand forms go out to the bus first
				if (op[1] && !op[2] && op != OP_DECIMAL_ADJUST && !opnd_ready && op != OP_STORE_R && op != OP_STORE_A) begin
					next_mem.req = 1'b1;
					next_mem.write = 1'b0;
					next_mem.addr = eaddr;
					next_state = CODS_MEM;
				end else if ((op == OP_STORE_R || op == OP_STORE_A) && !opnd_ready) begin
					next_mem.req = 1'b1;
					next_mem.write = 1'b1;
					next_mem.addr = eaddr;
					next_mem.wdata = rv;
					next_state = CODS_MEM;
				end else begin
					opnd = (op[1:0] == MODE_REG) ? ((op[5:2] == 4'hC) ? rv : r0v) : (op[1] ? b3 : b2);
					if (op[1:0] == MODE_REG) begin
						opnd = rv;
					end
					if (op[1] && !op[2]) begin
						opnd = b3;
					end else if (op[1:0] == MODE_IMM) begin
						opnd = b2;
					end
					tgt_is_r0 = (op[1:0] == MODE_REG) && op[2:0] != 3'h4 && op != OP_DECIMAL_ADJUST;
					dst = tgt_is_r0 ? r0v : rv;
					cin = lsb[LSB_CARRY_IN_EN] & lsb[LSB_CARRY];
					// branch groups share group codes with rotate and adjust, so keep them out
					case ((op[2:1] == 2'h3) ? 4'h1 : op[5:2])
						4'h0: begin
							res = opnd;
							next_regs[tgt_is_r0 ? r0i : ri] = res;
							next_lsb[LSB_CC_HIGH:LSB_CC_LOW] = cods_cc(res);
						end
						4'h8: begin
							sum = {1'b0, dst} + {1'b0, opnd} + {8'h00, cin};
							hsum = {1'b0, dst[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
							res = sum[7:0];
							next_regs[tgt_is_r0 ? r0i : ri] = res;
							next_lsb[LSB_CARRY] = sum[8];
							next_lsb[LSB_HALF_CARRY] = hsum[4];
							next_lsb[LSB_OVERFLOW] = (dst[7] == opnd[7]) && (res[7] != dst[7]);
							next_lsb[LSB_CC_HIGH:LSB_CC_LOW] = cods_cc(res);
						end
						4'hA: begin
							sum = {1'b0, dst} - {1'b0, opnd} - {8'h00, cin};
							hsum = {1'b0, dst[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cin};
							res = sum[7:0];
							next_regs[tgt_is_r0 ? r0i : ri] = res;
							next_lsb[LSB_CARRY] = sum[8];
							next_lsb[LSB_HALF_CARRY] = hsum[4];
							next_lsb[LSB_OVERFLOW] = (dst[7] != opnd[7]) && (res[7] != dst[7]);
							next_lsb[LSB_CC_HIGH:LSB_CC_LOW] = cods_cc(res);
						end
						4'h9: begin
							// decimal adjust: correct each digit lacking a carry
							res = rv;
							if (!lsb[LSB_CARRY]) begin
								res = 8'(res + 8'hA0);
							end
							if (!lsb[LSB_HALF_CARRY]) begin
								res = {res[7:4], 4'(res[3:0] + 4'hA)};
							end
							next_regs[ri] = res;
							next_lsb[LSB_CC_HIGH:LSB_CC_LOW] = cods_cc(res);
						end
						4'h4, 4'h6, 4'h2: begin
							if (op == OP_AND_Z && rf == 2'h0) begin
								next_illegal = 1'b1;
							end else begin
								res = (op[5:2] == 4'h4) ? (dst & opnd) : (op[5:2] == 4'h6) ? (dst | opnd) : (dst ^ opnd);
								next_regs[tgt_is_r0 ? r0i : ri] = res;
								next_lsb[LSB_CC_HIGH:LSB_CC_LOW] = cods_cc(res);
							end
						end
						4'hE: begin
							// compare: signed unless unsigned test bit set
							if (lsb[LSB_UNSIGNED_TEST] ? (dst == opnd) : (dst == opnd)) begin
								next_lsb[LSB_CC_HIGH:LSB_CC_LOW] = CC_ZERO;
							end else if (lsb[LSB_UNSIGNED_TEST] ? (dst > opnd) : ($signed(dst) > $signed(opnd))) begin
								next_lsb[LSB_CC_HIGH:LSB_CC_LOW] = CC_POS;
							end else begin
								next_lsb[LSB_CC_HIGH:LSB_CC_LOW] = CC_NEG;
							end
						end
						4'h5, 4'hD: begin
							// rotate, through carry when enabled
							if (op == OP_ROTATE_RIGHT) begin
								res = lsb[LSB_CARRY_IN_EN] ? {lsb[LSB_CARRY], rv[7:1]} : {rv[0], rv[7:1]};
								next_lsb[LSB_CARRY] = lsb[LSB_CARRY_IN_EN] ? rv[0] : lsb[LSB_CARRY];
								next_lsb[LSB_HALF_CARRY] = lsb[LSB_CARRY_IN_EN] ? rv[6] : lsb[LSB_HALF_CARRY];
							end else begin
								res = lsb[LSB_CARRY_IN_EN] ? {rv[6:0], lsb[LSB_CARRY]} : {rv[6:0], rv[7]};
								next_lsb[LSB_CARRY] = lsb[LSB_CARRY_IN_EN] ? rv[7] : lsb[LSB_CARRY];
								next_lsb[LSB_HALF_CARRY] = lsb[LSB_CARRY_IN_EN] ? rv[4] : lsb[LSB_HALF_CARRY];
							end
							next_regs[ri] = res;
							next_lsb[LSB_OVERFLOW] = rv[7] ^ res[7];
							next_lsb[LSB_CC_HIGH:LSB_CC_LOW] = cods_cc(res);
						end
						4'h1: begin
							taken = 1'b0;
						end
						default: begin
							if (op == OP_STORE_Z) begin
								if (rf == 2'h0) begin
									next_illegal = 1'b1;
								end else begin
									next_regs[ri] = r0v;
									next_lsb[LSB_CC_HIGH:LSB_CC_LOW] = cods_cc(r0v);
								end
							end
						end
					endcase
					// branch groups: flags untouched
					if (op[2:1] == 2'h3) begin
						case (op[5:3])
							3'h0: taken = (rf == 2'h3) || (lsb[LSB_CC_HIGH:LSB_CC_LOW] == rf);
							3'h4: taken = (rf != 2'h3) && (lsb[LSB_CC_HIGH:LSB_CC_LOW] != rf);
							3'h2: taken = (rv != 8'h00);
							default: begin
								next_regs[ri] = 8'(rv + 8'h01);
								taken = (8'(rv + 8'h01) != 8'h00);
							end
						endcase
						next_lsb = lsb;
						if (taken) begin
							next_pc = eaddr;
						end
					end
					next_mem.req = 1'b0;
					next_mem.write = 1'b0;
					next_opnd_ready = 1'b0;
					next_state = (cyc + 3'h1 < ncyc) ? CODS_PAD : CODS_FETCH1;
					next_retire = !(cyc + 3'h1 < ncyc);
					next_cyc = 3'(cyc + 3'h1);
				end
			end
			CODS_MEM: begin
				// drop the request on the answer edge so memory sees no second access
				if (i_mem.ack) begin
					next_mem.req = 1'b0;
					next_mem.write = 1'b0;
					next_opnd_ready = 1'b1;
					if (!mem.write) begin
						next_b3 = i_mem.rdata;
					end
					next_state = CODS_EXEC;
				end
			end
			default: begin
				// pad to the documented cycle count
				next_cyc = 3'(cyc + 3'h1);
				if (cyc + 3'h1 >= ncyc) begin
					next_state = CODS_FETCH1;
					next_retire = 1'b1;
				end
			end
		endcase
		if (i_status_we) begin
			next_lsb = i_status_wdata;
		end
		if (i_upper_we) begin
			next_usb = i_upper_wdata;
		end
	end

	// state registers; reset clears the program counter
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state <= CODS_FETCH1;
			lsb <= LSB_RESET;
			usb <= USB_RESET;
			pc <= PC_RESET;
			ir <= 8'h00;
			b2 <= 8'h00;
			b3 <= 8'h00;
			regs <= '{default: 8'h00};
			cyc <= 3'h0;
			mem <= '0;
			illegal <= 1'b0;
			retire <= 1'b0;
			opnd_ready <= 1'b0;
		end else begin
			state <= next_state;
			lsb <= next_lsb;
			usb <= next_usb;
			pc <= next_pc;
			ir <= next_ir;
			b2 <= next_b2;
			b3 <= next_b3;
			regs <= next_regs;
			cyc <= next_cyc;
			mem <= next_mem;
			illegal <= next_illegal;
			retire <= next_retire;
			opnd_ready <= next_opnd_ready;
		end
	end

	assign o_mem = mem;
	assign o_lower_status_byte = lsb;
	assign o_upper_status_byte = usb;
	assign o_pc = pc;
	assign o_illegal = illegal;
	assign o_retire = retire;
endmodule
`default_nettype wire

/* bench/cods_core_checker.sv */
// cods_core_checker: port-level checks on the decode and status byte block
// assumes one clock domain; bound to every cods_core instance below
`timescale 1ns/1ps
`default_nettype none
module cods_core_checker
	import cods_pkg::*;
(
	input wire logic i_clk, // clock
	input wire logic i_rst_b, // reset, active low
	input wire cods_mem_rsp_t i_mem, // memory answer
	input wire logic i_status_we, // lower write strobe
	input wire logic [7:0] i_status_wdata, // lower write data
	input wire logic i_upper_we, // upper write strobe
	input wire logic [7:0] i_upper_wdata, // upper write data
	input wire cods_mem_req_t o_mem, // memory request
	input wire logic [7:0] o_lower_status_byte, // lower status
	input wire logic [7:0] o_upper_status_byte, // upper status
	input wire logic [14:0] o_pc, // program counter
	input wire logic o_illegal, // invalid form pulse
	input wire logic o_retire // retire pulse
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// a new fetch follows a finished instruction
	sequence s_refetch;
		##[1:4] o_mem.req;
	endsequence
	// a waiting request keeps its qualifiers
	sequence s_held;
		o_mem.req && $stable(o_mem.addr) && $stable(o_mem.write) && $stable(o_mem.wdata);
	endsequence
	// checks on the ports
	reset_clears_a: assert property ($rose(i_rst_b) |->
		o_pc == PC_RESET && o_lower_status_byte == LSB_RESET && !o_mem.req) else $error("not cleared by reset");
	req_held_a: assert property (o_mem.req && !i_mem.ack |=> s_held) else $error("request dropped early");
	lower_write_a: assert property (i_status_we |=>
		o_lower_status_byte == $past(i_status_wdata)) else $error("lower status write lost");
	upper_write_a: assert property (i_upper_we |=>
		o_upper_status_byte == $past(i_upper_wdata)) else $error("upper status write lost");
	store_flags_a: assert property (o_mem.req && o_mem.write && !i_status_we |=>
		$stable(o_lower_status_byte)) else $error("store changed flags");
	pc_step_a: assert property (o_mem.req && i_mem.ack && !o_mem.write && o_mem.addr == o_pc |=>
		o_pc == $past(o_pc) + 15'h0001) else $error("pc not stepped on fetch");
	refetch_due_a: assert property (o_retire |-> s_refetch) else $error("no fetch after retire");
	illegal_pulse_a: assert property (o_illegal |=> !o_illegal) else $error("illegal not a pulse");
	retire_pulse_a: assert property (o_retire |=> !o_retire) else $error("retire not a pulse");
endmodule
bind cods_core cods_core_checker cods_core_checker_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_mem(i_mem),
	.i_status_we(i_status_we), .i_status_wdata(i_status_wdata), .i_upper_we(i_upper_we),
	.i_upper_wdata(i_upper_wdata), .o_mem(o_mem), .o_lower_status_byte(o_lower_status_byte),
	.o_upper_status_byte(o_upper_status_byte), .o_pc(o_pc), .o_illegal(o_illegal), .o_retire(o_retire));
`default_nettype wire

/* bench/cods_mem_model.sv */
// cods_mem_model: behavioural program memory on the far side of the block
// assumes requests stay up until ack; 64 bytes, loaded by the bench
`timescale 1ns/1ps
`default_nettype none
module cods_mem_model
	import cods_pkg::*;
(
	input wire logic i_clk, // clock
	input wire logic i_rst_b, // reset, active low
	input wire cods_mem_req_t i_req, // request from the block
	input wire logic [1:0] i_wait, // idle cycles before each answer
	output var cods_mem_rsp_t o_rsp // answer
);
	logic [7:0] mem [0:63];
	logic [1:0] cnt;
	logic ack;
	logic [7:0] rd;
	assign o_rsp = {ack, rd};
	// one ack pulse per request; read data scrambled outside the ack
	always @(posedge i_clk) begin
		if (!i_rst_b || ack) begin
			ack <= 1'b0;
			cnt <= 2'h0;
		end else if (i_req.req && cnt == i_wait) begin
			ack <= 1'b1;
			if (i_req.write)
				mem[i_req.addr[5:0]] <= i_req.wdata;
		end else if (i_req.req)
			cnt <= cnt + 2'h1;
		if (!i_rst_b)
			rd <= 8'hA5;
		else if (i_req.req && !i_req.write && !ack && cnt == i_wait)
			rd <= mem[i_req.addr[5:0]];
		else
			rd <= ~rd;
	end
endmodule
`default_nettype wire

/* bench/cods_core_tb.sv */
// cods_core_tb: self-checking bench for the decode and status byte block
// assumes cods_mem_model as program memory and the bound checker
`timescale 1ns/1ps
`default_nettype none
module cods_core_tb import cods_pkg::*;;
	typedef struct packed {
		logic [7:0] lower_status_byte;
		logic [7:0] v1;
		logic [5:0] op;
		logic [7:0] v2;
		logic [7:0] exp;
	} cods_row_t;
	// preset status, load value, immediate op, operand, status expected
	cods_row_t rows [0:9] = '{'{8'h00, 8'h7F, 6'h21, 8'h01, 8'hA4}, '{8'h09, 8'hFF, 6'h21, 8'h00, 8'h29},
		'{8'h00, 8'h10, 6'h29, 8'h20, 8'h81}, '{8'h13, 8'hF0, 6'h11, 8'h0F, 8'h13},
		'{8'h00, 8'h01, 6'h19, 8'h40, 8'h40}, '{8'h00, 8'hAA, 6'h09, 8'h2A, 8'h80},
		'{8'h00, 8'h80, 6'h39, 8'h01, 8'h80}, '{8'h02, 8'h80, 6'h39, 8'h01, 8'h42},
		'{8'h24, 8'h33, 6'h01, 8'h00, 8'h24}, '{8'h00, 8'h55, 6'h39, 8'h55, 8'h00}};
	logic clk, rst_b, status_we, upper_we, illegal, retire, seen;
	logic [7:0] status_wdata, upper_wdata, lower, upper;
	logic [14:0] pc;
	logic [1:0] wait_c;
	cods_mem_req_t mreq;
	cods_mem_rsp_t mrsp;
	int n_mismatch, comparisons, t;
	cods_core cods_core_inst (.i_clk(clk), .i_rst_b(rst_b), .i_mem(mrsp), .i_status_we(status_we),
		.i_status_wdata(status_wdata), .i_upper_we(upper_we), .i_upper_wdata(upper_wdata), .o_mem(mreq),
		.o_lower_status_byte(lower), .o_upper_status_byte(upper), .o_pc(pc), .o_illegal(illegal),
		.o_retire(retire));
	cods_mem_model cods_mem_model_inst (.i_clk(clk), .i_rst_b(rst_b), .i_req(mreq), .i_wait(wait_c),
		.o_rsp(mrsp));
	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// reset, preset the lower status byte, wait for nret retirements
	task automatic run(input logic [7:0] lower_status_byte, input logic [1:0] w, input int nret);
		@(posedge clk);
		rst_b <= 1'b0;
		wait_c <= w;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		status_we <= 1'b1;
		status_wdata <= lower_status_byte;
		@(posedge clk);
		status_we <= 1'b0;
		for (t = 0; t < 300 && nret > 0; t++) begin
			@(negedge clk);
			if (retire === 1'b1)
				nret--;
		end
		chk(15'(nret), 15'h0000, "retire count");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard, far beyond the expected run length
	initial begin
		#200000;
		n_mismatch++;
		$display("BAD t=%0t watchdog expired", $time);
		report_and_stop();
	end
	// main sequence
	initial begin
		rst_b = 1'b0;
		status_we = 1'b0;
		status_wdata = 8'h00;
		upper_we = 1'b0;
		upper_wdata = 8'h00;
		wait_c = 2'h0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		chk({7'h00, lower}, 15'h0000, "reset lower");
		chk(pc, 15'h0000, "reset pc");
		chk({14'h0000, mreq.req}, 15'h0000, "reset req");
		$display("test reset done");
		// load, op immediate, then branch-always to itself at 4
		for (int w = 0; w < 3; w += 2) begin
			foreach (rows[i]) begin
				cods_mem_model_inst.mem[0] = 8'h04;
				cods_mem_model_inst.mem[1] = rows[i].v1;
				cods_mem_model_inst.mem[2] = {rows[i].op, 2'h0};
				cods_mem_model_inst.mem[3] = rows[i].v2;
				cods_mem_model_inst.mem[4] = 8'h1F;
				cods_mem_model_inst.mem[5] = 8'h00;
				cods_mem_model_inst.mem[6] = 8'h04;
				run(rows[i].lower_status_byte, w[1:0], 3);
				chk({7'h00, lower}, {7'h00, rows[i].exp}, "status");
				chk(pc, 15'h0004, "pc");
				$display("test row %0d wait %0d done", i, w);
			end
		end
		// store absolute, invalid store form, then branch loop at 6
		cods_mem_model_inst.mem[0] = 8'h04;
		cods_mem_model_inst.mem[1] = 8'h5A;
		cods_mem_model_inst.mem[2] = 8'hCC;
		cods_mem_model_inst.mem[3] = 8'h00;
		cods_mem_model_inst.mem[4] = 8'h30;
		cods_mem_model_inst.mem[5] = 8'hC0;
		cods_mem_model_inst.mem[6] = 8'h1F;
		cods_mem_model_inst.mem[7] = 8'h00;
		cods_mem_model_inst.mem[8] = 8'h06;
		cods_mem_model_inst.mem[48] = 8'h00;
		run(8'h00, 2'h2, 2);
		chk({7'h00, cods_mem_model_inst.mem[48]}, 15'h005A, "stored byte");
		chk({7'h00, lower}, 15'h0040, "flags after store");
		seen = 1'b0;
		for (t = 0; t < 60; t++) begin
			@(negedge clk);
			if (illegal === 1'b1)
				seen = 1'b1;
		end
		chk({14'h0000, seen}, 15'h0001, "invalid form flagged");
		chk({7'h00, lower}, 15'h0040, "flags after invalid form");
		@(posedge clk);
		upper_we <= 1'b1;
		upper_wdata <= 8'hA5;
		@(posedge clk);
		upper_we <= 1'b0;
		@(negedge clk);
		chk({7'h00, upper}, 15'h00A5, "upper byte");
		$display("test store and invalid form done");
		// absolute load, rotate left through carry, branch false back onto itself
		cods_mem_model_inst.mem[0] = 8'h0C;
		cods_mem_model_inst.mem[1] = 8'h00;
		cods_mem_model_inst.mem[2] = 8'h30;
		cods_mem_model_inst.mem[3] = 8'hD0;
		cods_mem_model_inst.mem[4] = 8'h9A;
		cods_mem_model_inst.mem[5] = 8'h7E;
		cods_mem_model_inst.mem[48] = 8'h81;
		run(8'h08, 2'h0, 3);
		chk({7'h00, lower}, 15'h004D, "flags after rotate");
		chk(pc, 15'h0004, "relative branch back");
		$display("test rotate and branch false done");
		// bank 1 register: increment loop, nonzero test, decimal adjust, branch loop at 7
		cods_mem_model_inst.mem[0] = 8'h05;
		cods_mem_model_inst.mem[1] = 8'hFE;
		cods_mem_model_inst.mem[2] = 8'hD9;
		cods_mem_model_inst.mem[3] = 8'h7E;
		cods_mem_model_inst.mem[4] = 8'h59;
		cods_mem_model_inst.mem[5] = 8'h7A;
		cods_mem_model_inst.mem[6] = 8'h95;
		cods_mem_model_inst.mem[7] = 8'h1F;
		cods_mem_model_inst.mem[8] = 8'h00;
		cods_mem_model_inst.mem[9] = 8'h07;
		run(8'h11, 2'h2, 6);
		chk({7'h00, lower}, 15'h0051, "flags after decimal adjust");
		chk(pc, 15'h0007, "pc after register branches");
		$display("test register branches and adjust done");
		report_and_stop();
	end
endmodule
`default_nettype wire
